// ### design/pcs_pkg.sv
package pcs_pkg;

  // Register byte offsets on the plain register port.
  localparam logic [7:0] OFS_INT_STATUS  = 8'h00;
  localparam logic [7:0] OFS_INT_MASK    = 8'h04;
  localparam logic [7:0] OFS_CHAN_STATUS = 8'h08;

  // Widths of the ports and fields.
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int CODE_W  = 16;
  localparam int HW_W    = 16;
  localparam int EVT_W   = 3;
  localparam int PIN_W   = 8;

  // Test levels carried in the function code of a test instruction.
  localparam logic [15:0] LEVEL_INITIAL = 16'h8000;
  localparam logic [15:0] LEVEL_CHANNEL = 16'h4000;
  localparam logic [15:0] LEVEL_DEVICE  = 16'h2000;

  // Condition flag positions; flag 1 is the leftmost bit of the field.
  localparam int CC1_POS = 3;
  localparam int CC2_POS = 2;
  localparam int CC3_POS = 1;
  localparam int CC4_POS = 0;

  // Status halfword bit indices, numbered from the right (bit 0 is the LSB).
  localparam int HW_PV_POS   = 14;
  localparam int HW_INOP_POS = 13;
  localparam int HW_BOF_POS  = 6;
  localparam int HW_BUSY_POS = 2;

  // Interrupt event bits.
  localparam int EV_DONE_POS   = 0;
  localparam int EV_CHERR_POS  = 1;
  localparam int EV_DEVPV_POS  = 2;

  // Synchronised printer pin positions.
  localparam int PIN_BOF_POS = 7;

  // Reset values.
  localparam logic [2:0]  MASK_RST   = 3'h0;
  localparam logic [3:0]  FLAG_RST   = 4'h0;
  localparam logic [15:0] HW_RST     = 16'h0000;

  typedef enum logic {ST_IDLE, ST_BUSY} pcs_state_type;

endpackage

// ### design/pcs_sync.sv
`timescale 1ns/1ps
module pcs_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // Two flops per pin; the first stage is seen only by the second.
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          stage1[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i]   <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

// ### design/pcs_irq.sv
`timescale 1ns/1ps
module pcs_irq (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [pcs_pkg::EVT_W-1:0] event_in,
  input  wire logic                      wr_status,
  input  wire logic                      wr_mask,
  input  wire logic [pcs_pkg::EVT_W-1:0] wdata,
  output logic      [pcs_pkg::EVT_W-1:0] status,
  output logic      [pcs_pkg::EVT_W-1:0] mask,
  output logic                           irq
);
  import pcs_pkg::*;

  logic [EVT_W-1:0] next_status;

  // Write one to clear; a fresh event in the same cycle wins.
  assign next_status = event_in |
                       (status & ~(wr_status ? wdata : {EVT_W{1'b0}}));

  // Status, mask and the level interrupt all come from flops.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= {EVT_W{1'b0}};
      mask   <= MASK_RST;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      if (wr_mask) begin
        mask <= wdata;
      end
      irq <= |(next_status & (wr_mask ? wdata : mask));
    end
  end

endmodule

// ### design/pcs_channel_status.sv
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// R1: Initial level flag 2 shows channel active.
// R2: Initial level flag 1 always reads zero.
// R3: Initial level flag 3 shows previous channel error.
// R4: Initial level flag 4 shows printer abnormal.
// R5: Channel level flag 1: invalid memory access.
// R6: Channel level flag 2: memory parity error.
// R7: Overlapping command: violation, interrupt at end.
// R8: Channel level flag 4: output data lost.
// R9: Unperformable command: status bit 1, interrupt, terminate.
// R10: Status bit 2 shows printer inoperable.
// R11: Status bit 9 shows bottom of form.
// R12: Status bit 13 busy until completion interrupt.
// R13: Flags return to the processor status word.
module pcs_channel_status (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [pcs_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic [pcs_pkg::DATA_W-1:0] bus_wdata,
  input  wire logic                       bus_wr,
  input  wire logic                       bus_rd,
  output logic      [pcs_pkg::DATA_W-1:0] bus_rdata,
  input  wire logic                       test_valid,
  input  wire logic [pcs_pkg::CODE_W-1:0] test_code,
  input  wire logic                       command_valid,
  input  wire logic                       command_supported,
  input  wire logic                       op_done,
  input  wire logic                       mem_invalid,
  input  wire logic                       mem_parity,
  input  wire logic                       data_lost,
  input  wire logic                       pin_drum_arm_open,
  input  wire logic                       pin_format_reader_open,
  input  wire logic                       pin_hammer_fuse_open,
  input  wire logic                       pin_voltage_bad,
  input  wire logic                       pin_paper_out,
  input  wire logic                       pin_device_absent,
  input  wire logic                       pin_power_off,
  input  wire logic                       pin_bottom_of_form,
  output logic      [3:0]                 condition_flag,
  output logic                            condition_valid,
  output logic      [pcs_pkg::HW_W-1:0]   status_halfword,
  output logic                            service_req,
  output logic                            irq
);
  import pcs_pkg::*;

  pcs_state_type state;
  pcs_state_type next_state;

  logic [PIN_W-1:0] pins_sync;
  logic             inoperable;
  logic             bottom_of_form;

  logic err_mem_invalid;
  logic err_parity;
  logic err_chan_pv;
  logic err_overflow;
  logic dev_pv;
  logic chan_error;
  logic dev_abnormal;
  logic busy;

  logic accept;
  logic reject;
  logic overlap;
  logic finish;

  logic next_mem_invalid;
  logic next_parity;
  logic next_chan_pv;
  logic next_overflow;
  logic next_dev_pv;
  logic next_service_req;

  logic [3:0]       next_flags;
  logic [3:0]       flags_initial;
  logic [3:0]       flags_channel;
  logic [HW_W-1:0]  next_halfword;

  logic [EVT_W-1:0] irq_events;
  logic [EVT_W-1:0] irq_status;
  logic [EVT_W-1:0] irq_mask;
  logic             wr_int_status;
  logic             wr_int_mask;
  logic             sel_status;
  logic             sel_mask;
  logic             sel_chan;
  logic [DATA_W-1:0] next_rdata;

  // Printer pins are asynchronous and pass two flops before use.
  pcs_sync #(
    .W (PIN_W)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({pin_bottom_of_form, pin_power_off, pin_device_absent,
                pin_paper_out, pin_voltage_bad, pin_hammer_fuse_open,
                pin_format_reader_open, pin_drum_arm_open}),
    .sync_out (pins_sync)
  );

  // Any one cause makes the printer inoperable.
  assign inoperable     = |pins_sync[PIN_BOF_POS-1:0];   // [R10]
  assign bottom_of_form = pins_sync[PIN_BOF_POS];        // [R11]

  // Command decode against the current channel state.
  assign busy    = (state == ST_BUSY);
  assign accept  = command_valid && !busy && command_supported;
  assign reject  = command_valid && !busy && !command_supported; // [R9]
  assign overlap = command_valid && busy;                        // [R7]
  assign finish  = busy && op_done;

  // Busy runs from acceptance to the completion interrupt.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_BUSY;                          // [R12]
        end
      end
      ST_BUSY: begin
        if (op_done) begin
          next_state = ST_IDLE;                          // [R12]
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Errors describe the previous operation, so a new accepted command
  // starts them fresh; a detection in that same cycle still wins.
  assign next_mem_invalid = mem_invalid || (err_mem_invalid && !accept); // [R5]
  assign next_parity      = mem_parity || (err_parity && !accept);       // [R6]
  assign next_chan_pv     = overlap || (err_chan_pv && !accept);         // [R7]
  assign next_overflow    = data_lost || (err_overflow && !accept);      // [R8]
  assign next_dev_pv      = reject || (dev_pv && !accept);               // [R9]

  // Completion raises the service interrupt; an overlapped command
  // waits for it, while a refused one is answered at once.
  assign next_service_req = finish || reject;            // [R7] [R9]

  assign chan_error   = err_mem_invalid || err_parity ||
                        err_chan_pv || err_overflow;
  assign dev_abnormal = inoperable || dev_pv;

  // Flag sets for the initial and channel test levels; flag 1 of the initial level is unused.
  assign flags_initial = {1'b0,                          // [R2]
                          busy,                          // [R1]
                          chan_error,                    // [R3]
                          dev_abnormal};                 // [R4]
  assign flags_channel = {err_mem_invalid,               // [R5]
                          err_parity,                    // [R6]
                          err_chan_pv,                   // [R7]
                          err_overflow};                 // [R8]

  // Level select; the device level answers through the halfword.
  assign next_flags = (test_code == LEVEL_INITIAL) ? flags_initial :
                      (test_code == LEVEL_CHANNEL) ? flags_channel :
                      FLAG_RST;

  // Live device status halfword.
  always_comb begin
    next_halfword              = HW_RST;
    next_halfword[HW_PV_POS]   = dev_pv;                 // [R9]
    next_halfword[HW_INOP_POS] = inoperable;             // [R10]
    next_halfword[HW_BOF_POS]  = bottom_of_form;         // [R11]
    next_halfword[HW_BUSY_POS] = busy;                   // [R12]
  end

  // Channel state and sticky error flags.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state           <= ST_IDLE;
      err_mem_invalid <= 1'b0;
      err_parity      <= 1'b0;
      err_chan_pv     <= 1'b0;
      err_overflow    <= 1'b0;
      dev_pv          <= 1'b0;
    end else begin
      state           <= next_state;
      err_mem_invalid <= next_mem_invalid;
      err_parity      <= next_parity;
      err_chan_pv     <= next_chan_pv;
      err_overflow    <= next_overflow;
      dev_pv          <= next_dev_pv;
    end
  end

  // Processor-facing outputs, all registered, answered next cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      condition_flag  <= FLAG_RST;
      condition_valid <= 1'b0;
      status_halfword <= HW_RST;
      service_req     <= 1'b0;
    end else begin
      condition_valid <= test_valid;                     // [R13]
      if (test_valid) begin
        condition_flag <= next_flags;                    // [R13]
      end
      status_halfword <= next_halfword;
      service_req     <= next_service_req;
    end
  end

  // Interrupt events: service request on completion or refusal, channel error, device violation.
  assign irq_events[EV_DONE_POS]  = next_service_req;
  assign irq_events[EV_CHERR_POS] = mem_invalid || mem_parity ||
                                    data_lost || overlap;
  assign irq_events[EV_DEVPV_POS] = reject;

  // Register port decode.
  assign sel_status    = (bus_addr == OFS_INT_STATUS);
  assign sel_mask      = (bus_addr == OFS_INT_MASK);
  assign sel_chan      = (bus_addr == OFS_CHAN_STATUS);
  assign wr_int_status = bus_wr && sel_status;
  assign wr_int_mask   = bus_wr && sel_mask;

  pcs_irq u_irq (
    .clk       (clk),
    .rst_n     (rst_n),
    .event_in  (irq_events),
    .wr_status (wr_int_status),
    .wr_mask   (wr_int_mask),
    .wdata     (bus_wdata[EVT_W-1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  // Unmapped addresses read zero; the channel word mirrors the state.
  assign next_rdata =
    sel_status ? {{(DATA_W-EVT_W){1'b0}}, irq_status} :
    sel_mask   ? {{(DATA_W-EVT_W){1'b0}}, irq_mask} :
    sel_chan   ? {next_halfword, {(DATA_W-HW_W-8){1'b0}},
                  flags_channel, flags_initial} :
    {DATA_W{1'b0}};

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_rdata <= {DATA_W{1'b0}};
    end else begin
      bus_rdata <= bus_rd ? next_rdata : {DATA_W{1'b0}};
    end
  end

  // Checks on the live logic.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_refused;
    command_valid && !busy && !command_supported;
  endsequence

  sequence s_overlap;
    command_valid && busy;
  endsequence

  sequence s_overlap_end;
    busy && op_done && err_chan_pv;
  endsequence

  a_busy_accept: assert property ( // [R12]
    accept |=> busy ##1 status_halfword[HW_BUSY_POS])
    else $error("Busy did not follow an accepted command.");

  a_busy_done: assert property ( // [R12]
    finish |=> !busy && service_req)
    else $error("Completion did not end busy with a service request.");

  a_cc1_zero: assert property ( // [R2]
    test_valid |=> !condition_flag[CC1_POS] ||
      $past(test_code) == LEVEL_CHANNEL)
    else $error("Unused initial flag was set.");

  a_cc2_active: assert property ( // [R1]
    test_valid && test_code == LEVEL_INITIAL |=>
      condition_valid && condition_flag[CC2_POS] == $past(busy))
    else $error("Channel active flag wrong.");

  a_cc3_error: assert property ( // [R3]
    test_valid && test_code == LEVEL_INITIAL |=>
      condition_flag[CC3_POS] == $past(chan_error))
    else $error("Channel error flag wrong.");

  a_cc4_device: assert property ( // [R4]
    test_valid && test_code == LEVEL_INITIAL |=>
      condition_flag[CC4_POS] == $past(dev_abnormal))
    else $error("Device status flag wrong.");

  a_mem_access: assert property ( // [R5]
    err_mem_invalid && test_valid && test_code == LEVEL_CHANNEL |=>
      condition_flag[CC1_POS])
    else $error("Invalid memory access not reported.");

  a_mem_parity: assert property ( // [R6]
    mem_parity |=> err_parity)
    else $error("Parity error not held.");

  a_overlap_pv: assert property ( // [R7]
    s_overlap |=> err_chan_pv)
    else $error("Overlapped command not flagged.");

  a_overlap_end: assert property ( // [R7]
    s_overlap_end |=> service_req && err_chan_pv && !busy)
    else $error("Overlapped command not flagged at completion.");

  a_overflow: assert property ( // [R8]
    err_overflow && test_valid && test_code == LEVEL_CHANNEL |=>
      condition_flag[CC4_POS])
    else $error("Lost output data not reported.");

  a_refused_cmd: assert property ( // [R9]
    s_refused |=> service_req && dev_pv && !busy
      ##1 status_halfword[HW_PV_POS])
    else $error("Refused command handled wrongly.");

  a_inop_bit: assert property ( // [R10]
    status_halfword[HW_INOP_POS] == $past(inoperable))
    else $error("Inoperable bit does not follow the pins.");

  a_bof_bit: assert property ( // [R11]
    status_halfword[HW_BOF_POS] == $past(pins_sync[PIN_BOF_POS]))
    else $error("Bottom-of-form bit does not follow the pin.");

  a_flag_timing: assert property ( // [R13]
    test_valid |=> condition_valid ##1 !condition_valid || $past(test_valid))
    else $error("Condition flags not answered in one cycle.");

  // Level 2000 answers through the halfword; its flags stay clear.
  a_device_level: assert property ( // [R13]
    test_valid && test_code == LEVEL_DEVICE |=>
      condition_valid && condition_flag == FLAG_RST)
    else $error("Device level returned condition flags.");

  // Busy may only end on a completion report from the channel.
  a_busy_hold: assert property ( // [R12]
    busy && !op_done |=> busy)
    else $error("Busy ended without completion.");

  // A clean accepted command starts with no old channel error on record.
  a_error_fresh: assert property ( // [R3]
    accept && !mem_invalid && !mem_parity && !data_lost |=> !chan_error)
    else $error("Old channel error survived a new command.");

endmodule

// ### test/pcs_cpu_model.sv
`timescale 1ns/1ps
// Processor side: register accesses, test and command instructions.
module pcs_cpu_model (
  input  wire logic                       clk,
  output logic      [pcs_pkg::ADDR_W-1:0] bus_addr,
  output logic      [pcs_pkg::DATA_W-1:0] bus_wdata,
  output logic                            bus_wr,
  output logic                            bus_rd,
  input  wire logic [pcs_pkg::DATA_W-1:0] bus_rdata,
  output logic                            test_valid,
  output logic      [pcs_pkg::CODE_W-1:0] test_code,
  output logic                            command_valid,
  output logic                            command_supported,
  input  wire logic [3:0]                 condition_flag,
  input  wire logic                       condition_valid,
  input  wire logic                       service_req
);
  import pcs_pkg::*;

  // Everything idles low from time zero so reset sees no request.
  initial begin
    {bus_addr, bus_wdata, bus_wr, bus_rd} = '0;
    {test_valid, test_code, command_valid, command_supported} = '0;
  end

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    #1;
  endtask

  // The answer is taken as the flags land in the status word.
  task automatic test(input logic [15:0] c, output logic [4:0] r);
    @(posedge clk);
    test_code <= c;
    test_valid <= 1'b1;
    @(posedge clk);
    test_valid <= 1'b0;
    #1 r = {condition_valid, condition_flag};
  endtask

  // Returns the service request seen in the cycle after the command.
  task automatic cmd(input logic ok, output logic s);
    @(posedge clk);
    command_supported <= ok;
    command_valid <= 1'b1;
    @(posedge clk);
    command_valid <= 1'b0;
    #1 s = service_req;
  endtask
endmodule

// ### test/pcs_channel_status_tb.sv
`timescale 1ns/1ps
module pcs_channel_status_tb;
  import pcs_pkg::*;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  ev = 4'h0;
  logic [7:0]  pins = 8'h00;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata;
  logic [31:0] bus_rdata;
  logic [31:0] d;
  logic        bus_wr;
  logic        bus_rd;
  logic        test_valid;
  logic [15:0] test_code;
  logic        command_valid;
  logic        command_supported;
  logic [3:0]  condition_flag;
  logic        condition_valid;
  logic [15:0] status_halfword;
  logic        service_req;
  logic        irq;
  logic        s;
  logic [4:0]  r;
  logic [3:0]  exp_tab [1:3] = '{4'h8, 4'h4, 4'h1};
  int          failures = 0;
  int          samples_checked = 0;

  always #20 clk = ~clk;

  pcs_cpu_model cpu (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .test_valid(test_valid), .test_code(test_code),
    .command_valid(command_valid), .command_supported(command_supported),
    .condition_flag(condition_flag),
    .condition_valid(condition_valid), .service_req(service_req));

  pcs_channel_status uut (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .test_valid(test_valid), .test_code(test_code),
    .command_valid(command_valid), .command_supported(command_supported),
    .op_done(ev[0]),
    .mem_invalid(ev[1]), .mem_parity(ev[2]), .data_lost(ev[3]),
    .pin_drum_arm_open(pins[0]), .pin_format_reader_open(pins[1]),
    .pin_hammer_fuse_open(pins[2]), .pin_voltage_bad(pins[3]),
    .pin_paper_out(pins[4]), .pin_device_absent(pins[5]),
    .pin_power_off(pins[6]), .pin_bottom_of_form(pins[7]),
    .condition_flag(condition_flag), .condition_valid(condition_valid),
    .status_halfword(status_halfword), .service_req(service_req),
    .irq(irq));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle pulse on the channel events; bit 0 is completion.
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    #1;
  endtask

  // Nothing here waits on the design, so a fixed limit catches a hang.
  initial begin
    #2000000;
    failures++;
    $display("FAIL watchdog expired");
    close_out();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    check("reset flags", condition_flag, FLAG_RST);
    check("reset halfword", status_halfword, HW_RST);
    cpu.rd(OFS_INT_MASK, d);
    check("reset mask", d, 32'h0);
    $display("test reset done");

    cpu.test(LEVEL_INITIAL, r);
    check("idle flags", r, 5'h10);
    cpu.cmd(1'b1, s);
    check("accept sreq", s, 1'b0);
    tick(1);
    check("busy bit", status_halfword, 16'h0004);
    cpu.test(LEVEL_INITIAL, r);
    check("active flags", r, 5'h14);
    cpu.cmd(1'b1, s);
    check("overlap sreq", s, 1'b0);
    cpu.test(LEVEL_CHANNEL, r);
    check("overlap flags", r, 5'h12);
    check("still busy", status_halfword, 16'h0004);
    pulse(4'h1);
    check("done sreq", service_req, 1'b1);
    tick(1);
    check("busy cleared", status_halfword, 16'h0000);
    cpu.test(LEVEL_INITIAL, r);
    check("error flags", r, 5'h12);
    cpu.rd(OFS_INT_STATUS, d);
    check("int status", d, 32'h3);
    cpu.wr(OFS_INT_STATUS, 32'h3);
    cpu.rd(OFS_INT_STATUS, d);
    check("int cleared", d, 32'h0);
    $display("test overlap done");

    // Each error event in turn; the next accepted command clears it.
    for (int i = 1; i < 4; i++) begin
      cpu.cmd(1'b1, s);
      pulse(4'h1 << i);
      pulse(4'h1);
      check("err sreq", service_req, 1'b1);
      cpu.test(LEVEL_CHANNEL, r);
      check("chan flags", r, {1'b1, exp_tab[i]});
      cpu.rd(OFS_CHAN_STATUS, d);
      check("chan word", d, {24'h0, exp_tab[i], 4'h2});
      cpu.wr(OFS_INT_STATUS, 32'h7);
    end
    $display("test channel errors done");

    cpu.cmd(1'b0, s);
    check("refuse sreq", s, 1'b1);
    tick(1);
    check("violation bit", status_halfword, 16'h4000);
    // The refused command is no operation, so the lost-data error of the
    // last accepted one still stands beside the device violation.
    cpu.test(LEVEL_INITIAL, r);
    check("abnormal", r, 5'h13);
    cpu.rd(OFS_INT_STATUS, d);
    check("viol event", d, 32'h5);
    cpu.wr(OFS_INT_STATUS, 32'h7);
    cpu.cmd(1'b1, s);
    pulse(4'h1);
    tick(1);
    check("viol cleared", status_halfword, 16'h0000);
    $display("test refusal done");

    // Every inoperable cause alone, then bottom of form.
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      pins <= 8'h01 << i;
      tick(4);
      check("inop bit", status_halfword, 16'h2000);
      cpu.test(LEVEL_INITIAL, r);
      check("inop flag", r, 5'h11);
      cpu.test(LEVEL_DEVICE, r);
      check("device level", r, 5'h10);
    end
    @(posedge clk);
    pins <= 8'h80;
    tick(4);
    check("bottom of form", status_halfword, 16'h0040);
    @(posedge clk);
    pins <= 8'h00;
    tick(4);
    check("pins idle", status_halfword, 16'h0000);
    $display("test pins done");

    cpu.wr(OFS_INT_STATUS, 32'h7);
    cpu.cmd(1'b1, s);
    pulse(4'h1);
    cpu.wr(OFS_INT_MASK, 32'h7);
    check("irq on", irq, 1'b1);
    cpu.rd(OFS_INT_MASK, d);
    check("mask back", d, 32'h7);
    cpu.wr(OFS_INT_MASK, 32'h0);
    check("irq masked", irq, 1'b0);
    cpu.wr(OFS_INT_MASK, 32'h1);
    check("irq again", irq, 1'b1);
    cpu.wr(OFS_INT_STATUS, 32'h1);
    tick(1);
    check("irq cleared", irq, 1'b0);
    cpu.rd(8'h0c, d);
    check("unmapped", d, 32'h0);
    $display("test interrupt done");
    close_out();
  end
endmodule
